// ===== src/ncap_defines.vh
`ifndef NCAP_DEFINES_VH
`define NCAP_DEFINES_VH

`define NCAP_CMD_READ_SETUP   8'h00
`define NCAP_CMD_READ_CONFIRM 8'h30
`define NCAP_CMD_TP_RAND_RD   8'h06
`define NCAP_CMD_RAND_CONFIRM 8'he0
`define NCAP_CMD_STATUS       8'h70
`define NCAP_ADDR_CYCLES      3'h5
`define NCAP_ROW_ADDR_CYCLES  3'h3
`define NCAP_COL_ADDR_CYCLES  3'h2
`define NCAP_STROBE_TICKS     4'h3
`define NCAP_PLANE_BIT_X8     6
`define NCAP_PLANE_BIT_X16    6
// 60 ns write-to-busy and write-to-read gap in 10 ns clock cycles
`define NCAP_WAIT_CYC         4'h6
`define NCAP_LAST_COL_X8      12'h83f
`define NCAP_LAST_COL_X16     12'h41f
`define NCAP_OP_READ          2'h0
`define NCAP_OP_TWO_PLANE     2'h1
`define NCAP_OP_SELECT        2'h2
`define NCAP_OP_DATA          2'h3
`define NCAP_BUS_X16          1'b1

`endif

// ===== src/ncap_host.v
// What this block does
// - Command cycles raise command qualifier, strobe latches
// - Address cycles raise address qualifier, strobe latches
// - x8 address: five bytes, column then row
// - x16 address: five cycles, upper lanes low
// - Unused address bit positions held low
// - Data out: qualifiers low, write strobe high
// - Page read: setup, five addresses, confirm
// - Two-plane read: two setups, addresses, confirm
// - Two-plane addresses differ only in plane bit
// - Plane chosen by two-plane random read codes
// - Only defined command codes are issued
// - Column changes stay inside loaded page
`timescale 1ns/1ps
`include "ncap_defines.vh"
module ncap_host (
    ref_clk,
    rst_n,
    op_valid,
    op_code,
    op_bus_x16,
    op_col,
    op_row,
    op_plane,
    op_ready,
    rd_data,
    rd_valid,
    cmd_latch,
    addr_latch,
    chip_en_n,
    write_strobe_n,
    read_strobe_n,
    io_out,
    io_oe,
    io_in,
    ready_busy_n
);
    input              ref_clk;
    input              rst_n;
    input              op_valid;
    input      [1:0]   op_code;
    input              op_bus_x16;
    input      [11:0]  op_col;
    input      [16:0]  op_row;
    input              op_plane;
    output reg         op_ready;
    output reg [15:0]  rd_data;
    output reg         rd_valid;
    output reg         cmd_latch;
    output reg         addr_latch;
    output reg         chip_en_n;
    output reg         write_strobe_n;
    output reg         read_strobe_n;
    output reg [15:0]  io_out;
    output reg         io_oe;
    input      [15:0]  io_in;
    input              ready_busy_n;

    localparam ST_IDLE  = 4'h0;
    localparam ST_CMD   = 4'h1;
    localparam ST_ADDR  = 4'h2;
    localparam ST_CMD2  = 4'h3;
    localparam ST_ADDR2 = 4'h4;
    localparam ST_CONF  = 4'h5;
    localparam ST_BUSY  = 4'h6;
    localparam ST_READ  = 4'h7;
    localparam ST_WAIT  = 4'h8;

    reg [3:0]  state_q;
    reg [2:0]  phase_q;
    reg [3:0]  tick_q;
    reg [2:0]  acyc_q;
    reg [1:0]  op_q;
    reg        x16_q;
    reg [11:0] col_q;
    reg [16:0] row_q;
    reg        plane_q;
    reg        second_q;
    reg [7:0]  abyte;
    reg [7:0]  ccode;
    reg [16:0] row_eff;
    reg [11:0] col_page;
    reg [11:0] rcol_q;
    reg        need_sel_q;
    reg        page_end;
    reg        refuse;

    // Plane bit forced into the row per bus width; both sets share all else
    always @*
    begin
        row_eff = row_q;
        if (x16_q)
            row_eff[`NCAP_PLANE_BIT_X16] = plane_q ^ second_q;
        else
            row_eff[`NCAP_PLANE_BIT_X8] = plane_q ^ second_q;
    end

    // Columns past the page end are clamped so a column move never leaves the page
    always @*
    begin
        col_page = op_col;
        if (op_bus_x16)
        begin
            if (op_col > `NCAP_LAST_COL_X16)
                col_page = `NCAP_LAST_COL_X16;
        end
        else if (op_col > `NCAP_LAST_COL_X8)
            col_page = `NCAP_LAST_COL_X8;
    end

    // Data words are refused until a plane is picked, and past the page end
    always @*
    begin
        page_end = x16_q ? (rcol_q > `NCAP_LAST_COL_X16) : (rcol_q > `NCAP_LAST_COL_X8);
        refuse   = (op_code == `NCAP_OP_DATA) && (need_sel_q || page_end);
    end

    // Address byte per cycle; unused positions zero
    always @*
    begin
        case (acyc_q)
            3'h0: abyte = col_q[7:0];
            3'h1: abyte = x16_q ? {5'h00, col_q[10:8]} : {4'h0, col_q[11:8]};
            3'h2: abyte = row_eff[7:0];
            3'h3: abyte = row_eff[15:8];
            3'h4: abyte = {7'h00, row_eff[16]};
            default: abyte = 8'h00;
        endcase
    end

    // Read codes only: erase and copy-back sequences are never issued
    always @*
    begin
        case (state_q)
            ST_CMD, ST_CMD2: ccode = (op_q == `NCAP_OP_SELECT) ? `NCAP_CMD_TP_RAND_RD : `NCAP_CMD_READ_SETUP;
            ST_CONF:         ccode = (op_q == `NCAP_OP_SELECT) ? `NCAP_CMD_RAND_CONFIRM
                                                            : `NCAP_CMD_READ_CONFIRM;
            default:         ccode = 8'h00;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_q        <= ST_IDLE;
            phase_q        <= 3'h0;
            tick_q         <= 4'h0;
            acyc_q         <= 3'h0;
            op_q           <= 2'h0;
            x16_q          <= 1'b0;
            col_q          <= 12'h000;
            row_q          <= 17'h00000;
            plane_q        <= 1'b0;
            second_q       <= 1'b0;
            rcol_q         <= 12'h000;
            need_sel_q     <= 1'b0;
            op_ready       <= 1'b0;
            rd_data        <= 16'h0000;
            rd_valid       <= 1'b0;
            cmd_latch      <= 1'b0;
            addr_latch     <= 1'b0;
            chip_en_n      <= 1'b1;
            write_strobe_n <= 1'b1;
            read_strobe_n  <= 1'b1;
            io_out         <= 16'h0000;
            io_oe          <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    cmd_latch  <= 1'b0;
                    addr_latch <= 1'b0;
                    io_oe      <= 1'b0;
                    op_ready   <= ready_busy_n;
                    // Refused requests are dropped with op_ready left high
                    if (op_valid && op_ready && ready_busy_n && !refuse)
                    begin
                        op_ready  <= 1'b0;
                        op_q      <= op_code;
                        x16_q     <= op_bus_x16;
                        col_q     <= col_page;
                        // The column mirror restarts where the device restarts its column
                        if (op_code != `NCAP_OP_DATA)
                            rcol_q <= col_page;
                        row_q     <= op_row;
                        plane_q   <= op_plane;
                        second_q  <= 1'b0;
                        acyc_q    <= 3'h0;
                        phase_q   <= 3'h0;
                        tick_q    <= 4'h0;
                        chip_en_n <= 1'b0;
                        state_q   <= (op_code == `NCAP_OP_DATA) ? ST_READ : ST_CMD;
                    end
                end
                ST_CMD, ST_CMD2, ST_CONF, ST_ADDR, ST_ADDR2:
                begin
                    // Each bus cycle: setup, strobe low, strobe high latches
                    tick_q <= tick_q + 4'h1;
                    if (tick_q == 4'h0)
                    begin
                        io_oe      <= 1'b1;
                        cmd_latch  <= (state_q == ST_CMD) || (state_q == ST_CMD2) || (state_q == ST_CONF);
                        addr_latch <= (state_q == ST_ADDR) || (state_q == ST_ADDR2);
                        io_out     <= ((state_q == ST_ADDR) || (state_q == ST_ADDR2)) ? {8'h00, abyte}
                                                                                     : {8'h00, ccode};
                    end
                    else if (tick_q == 4'h1)
                        write_strobe_n <= 1'b0;
                    else if (tick_q == `NCAP_STROBE_TICKS)
                        write_strobe_n <= 1'b1;
                    else if (tick_q > `NCAP_STROBE_TICKS)
                    begin
                        tick_q <= 4'h0;
                        case (state_q)
                            ST_CMD:  state_q <= ST_ADDR;
                            ST_CMD2: state_q <= ST_ADDR2;
                            ST_ADDR, ST_ADDR2:
                            begin
                                acyc_q <= acyc_q + 3'h1;
                                if (acyc_q == `NCAP_ADDR_CYCLES - 3'h1)
                                begin
                                    acyc_q <= 3'h0;
                                    if (op_q == `NCAP_OP_TWO_PLANE && state_q == ST_ADDR)
                                    begin
                                        second_q <= 1'b1;
                                        state_q  <= ST_CMD2;
                                    end
                                    else
                                        state_q <= ST_CONF;
                                end
                            end
                            default: state_q <= (op_q == `NCAP_OP_SELECT) ? ST_WAIT : ST_BUSY;
                        endcase
                    end
                end
                ST_BUSY:
                begin
                    // Device pulls busy within a few cycles, then releases
                    cmd_latch <= 1'b0;
                    io_oe     <= 1'b0;
                    tick_q    <= (tick_q == 4'hf) ? tick_q : tick_q + 4'h1;
                    if (tick_q >= `NCAP_WAIT_CYC && ready_busy_n)
                    begin
                        state_q   <= ST_IDLE;
                        chip_en_n <= 1'b1;
                        need_sel_q <= (op_q == `NCAP_OP_TWO_PLANE);
                    end
                end
                ST_WAIT:
                begin
                    cmd_latch <= 1'b0;
                    io_oe     <= 1'b0;
                    tick_q    <= tick_q + 4'h1;
                    // A select only needs the write-to-read gap; the page is already loaded
                    if (tick_q >= `NCAP_WAIT_CYC)
                    begin
                        need_sel_q <= 1'b0;
                        state_q   <= ST_IDLE;
                        chip_en_n <= 1'b1;
                    end
                end
                ST_READ:
                begin
                    // One word per read strobe pulse; device advances the column
                    io_oe          <= 1'b0;
                    write_strobe_n <= 1'b1;
                    tick_q         <= tick_q + 4'h1;
                    if (tick_q == 4'h0)
                        read_strobe_n <= 1'b0;
                    else if (tick_q == `NCAP_STROBE_TICKS)
                    begin
                        read_strobe_n <= 1'b1;
                        rd_data       <= x16_q ? io_in : {8'h00, io_in[7:0]};
                        rd_valid      <= 1'b1;
                        rcol_q        <= rcol_q + 12'h001;
                        tick_q        <= 4'h0;
                        state_q       <= ST_IDLE;
                        chip_en_n     <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== bench/ncap_host_assertions.sv
`timescale 1ns/1ps
module ncap_chk (
    input wire        ref_clk,
    input wire        rst_n,
    input wire        op_valid,
    input wire [1:0]  op_code,
    input wire        op_bus_x16,
    input wire [11:0] op_col,
    input wire [16:0] op_row,
    input wire        op_plane,
    input wire        op_ready,
    input wire [15:0] rd_data,
    input wire        rd_valid,
    input wire        cmd_latch,
    input wire        addr_latch,
    input wire        chip_en_n,
    input wire        write_strobe_n,
    input wire        read_strobe_n,
    input wire [15:0] io_out,
    input wire        io_oe,
    input wire [15:0] io_in,
    input wire        ready_busy_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    chk_qual_excl: assert property (!(cmd_latch && addr_latch))
        else $error("both qualifiers high");
    chk_write_hold: assert property (!write_strobe_n |-> io_oe && !chip_en_n && $stable(io_out)
        && (cmd_latch || addr_latch)) else $error("write cycle not held");
    chk_cmd_codes: assert property ($rose(write_strobe_n) && cmd_latch |->
        io_out[7:0] inside {8'h00, 8'h30, 8'h06, 8'he0, 8'h70}) else $error("undefined command");
    chk_addr_lanes: assert property (addr_latch && !write_strobe_n |-> io_out[15:8] == 8'h00)
        else $error("upper lanes not low");
    chk_read_quals: assert property (!read_strobe_n |->
        !cmd_latch && !addr_latch && !chip_en_n && write_strobe_n && !io_oe) else $error("bad read state");
    chk_read_ready: assert property ($fell(read_strobe_n) |-> ready_busy_n)
        else $error("read while busy");
    chk_busy_block: assert property (!ready_busy_n |=> !op_ready)
        else $error("ready while busy");
    chk_word_pulse: assert property ($rose(read_strobe_n) |-> ##[0:2] rd_valid ##1 !rd_valid)
        else $error("no single word pulse");
    cover property ($rose(rd_valid));
    cover property ($fell(ready_busy_n));
    cover property ($rose(write_strobe_n) && cmd_latch && io_out[7:0] == 8'h06);
endmodule
bind ncap_host ncap_chk chk_u (.ref_clk, .rst_n, .op_valid, .op_code, .op_bus_x16, .op_col, .op_row,
    .op_plane, .op_ready, .rd_data, .rd_valid, .cmd_latch, .addr_latch, .chip_en_n, .write_strobe_n,
    .read_strobe_n, .io_out, .io_oe, .io_in, .ready_busy_n);

// ===== bench/ncap_flash_model.sv
`timescale 1ns/1ps
module ncap_flash_model #(
    parameter integer ARRAY_READ_TIME = 200
) (
    input wire          bus_x16,
    input wire          cmd_latch,
    input wire          addr_latch,
    input wire          chip_en_n,
    input wire          write_strobe_n,
    input wire          read_strobe_n,
    input wire   [15:0] io_out,
    output logic [15:0] io_in,
    output logic        ready_busy_n
);
    logic [7:0]  cmd_q = 8'h00;
    logic [7:0]  addr_q [0:4];
    logic [2:0]  acnt_q = 3'h0;
    logic [11:0] col_q = 12'h000;
    logic        plane_q = 1'b0;
    initial io_in = 16'h5a5a;
    initial ready_busy_n = 1'b1;
    always @(posedge write_strobe_n)
    begin
        if (!chip_en_n && cmd_latch)
        begin
            cmd_q <= io_out[7:0];
            acnt_q <= 3'h0;
            if (io_out[7:0] == 8'h30 || io_out[7:0] == 8'he0)
            begin
                col_q <= {addr_q[1][3] & !bus_x16, addr_q[1][2:0], addr_q[0]};
                plane_q <= addr_q[2][6];
            end
            if (io_out[7:0] == 8'h30)
            begin
                ready_busy_n <= 1'b0;
                ready_busy_n <= #ARRAY_READ_TIME 1'b1;
            end
        end
        else if (!chip_en_n && addr_latch && acnt_q < 3'h5)
        begin
            addr_q[acnt_q] <= io_out[7:0];
            acnt_q <= acnt_q + 3'h1;
        end
    end
    // Upper byte on x8 is junk so the host must mask it
    always @(negedge read_strobe_n)
        io_in <= bus_x16 ? {4'h0, plane_q, col_q[10:0]} : {8'ha5, plane_q, col_q[6:0]};
    // Released bus shows the inverse so a late sample cannot match by luck
    always @(posedge read_strobe_n)
    begin
        col_q <= col_q + 12'h001;
        io_in <= ~io_in;
    end
endmodule

// ===== bench/ncap_host_test.sv
`timescale 1ns/1ps
module ncap_host_test;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        op_valid = 1'b0;
    logic [1:0]  op_code = 2'h0;
    logic        op_bus_x16 = 1'b0;
    logic [11:0] op_col = 12'h000;
    logic [16:0] op_row = 17'h1abcd;
    logic        op_plane = 1'b0;
    wire         op_ready, rd_valid, cmd_latch, addr_latch, chip_en_n;
    wire         write_strobe_n, read_strobe_n, io_oe, ready_busy_n;
    wire  [15:0] rd_data, io_out, io_in;
    integer      error_cnt = 0;
    integer      comparisons = 0;
    integer      cyc = 0;
    always #5 ref_clk = ~ref_clk;
    ncap_host dut_u (.ref_clk, .rst_n, .op_valid, .op_code, .op_bus_x16, .op_col, .op_row, .op_plane,
        .op_ready, .rd_data, .rd_valid, .cmd_latch, .addr_latch, .chip_en_n, .write_strobe_n,
        .read_strobe_n, .io_out, .io_oe, .io_in, .ready_busy_n);
    ncap_flash_model flash_u (.bus_x16(op_bus_x16), .cmd_latch, .addr_latch, .chip_en_n,
        .write_strobe_n, .read_strobe_n, .io_out, .io_in, .ready_busy_n);
    task check(input [15:0] seen, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task summarize;
    begin
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // A hang counts as a mismatch
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    task op(input [1:0] c, input [11:0] col, input pl);
    begin
        while (op_ready !== 1'b1) @(posedge ref_clk);
        op_code <= c;
        op_col <= col;
        op_plane <= pl;
        op_valid <= 1'b1;
        @(posedge ref_clk);
        while (op_ready !== 1'b1) @(posedge ref_clk);
        op_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    end
    endtask
    task rd(input [15:0] exp);
    begin
        op(2'h3, 12'h000, 1'b0);
        while (rd_valid !== 1'b1) @(posedge ref_clk);
        check(rd_data, exp);
    end
    endtask
    task addr_bytes(input [39:0] exp);
        integer i;
    begin
        for (i = 0; i < 5; i = i + 1)
            check({8'h00, flash_u.addr_q[i]}, {8'h00, exp[8*i +: 8]});
    end
    endtask
    // Start column near the page end, plane bit forced over row bit 6
    task s_page_x8;
    begin
        op_bus_x16 <= 1'b0;
        op(2'h0, 12'h83e, 1'b0);
        rd(16'h003e);
        addr_bytes(40'h01ab8d083e);
        check({8'h00, flash_u.cmd_q}, 16'h0030);
        rd(16'h003f);
        op(2'h3, 12'h000, 1'b0);
        repeat (8) @(posedge ref_clk);
        check({4'h0, flash_u.col_q}, 16'h0840);
    end
    endtask
    task s_page_x16;
    begin
        op_bus_x16 <= 1'b1;
        op(2'h0, 12'h41f, 1'b1);
        rd(16'h0c1f);
        addr_bytes(40'h01abcd041f);
        op(2'h0, 12'hfff, 1'b0);
        rd(16'h041f);
    end
    endtask
    task s_two_plane;
    begin
        op_bus_x16 <= 1'b0;
        op(2'h1, 12'h005, 1'b0);
        op(2'h3, 12'h000, 1'b0);
        repeat (8) @(posedge ref_clk);
        check({4'h0, flash_u.col_q}, 16'h0005);
        check({8'h00, flash_u.cmd_q}, 16'h0030);
        addr_bytes(40'h01abcd0005);
        op(2'h2, 12'h005, 1'b1);
        addr_bytes(40'h01abcd0005);
        rd(16'h0085);
        rd(16'h0086);
        op(2'h2, 12'h010, 1'b0);
        check({8'h00, flash_u.cmd_q}, 16'h00e0);
        rd(16'h0010);
    end
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        s_page_x8;
        s_page_x16;
        s_two_plane;
        summarize;
    end
endmodule
